// ---- verilog/fault_ext_gpio.sv ----
// Fault, sense, general and external pin GPIO with edge interrupts

// Summary of operation
// - Four drive bits set protection pin levels while the pin is an output.
// - Protection pin direction bit: 0 input (reset), 1 output.
// - Synchronised protection pin levels readable as read-only bits.
// - Protection pin interrupts need enable bits 3..0, cleared at reset.
// - Enable bits 4,5 gate sense pins A,B, only in general mode.
// - Enable bits 6,7 gate pins C,D, only in general mode.
// - Per-source polarity: 0 falling edge (reset), 1 rising edge.
// - Protection pending bits 3..0 set when the pin caused an event.
// - Pending bits 4..7 flag events from the remaining four sources.
// - Writing 1 clears a pending bit; writing 0 leaves it.
// - External pin direction bit: 0 input (reset), 1 output.
// - External pin level readable in read-only bit 0.
// - External pin driven to its output bit while an output.
// - External pin interrupt only while its enable is 1.
// - External polarity: 0 falling edge (reset), 1 rising edge.
// - External pending bit set by its event, cleared by writing 1.
module fault_ext_gpio
  import gio_pkg::*;
(
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [BE_W-1:0]   avs_byteenable_in,
  output logic      [DATA_W-1:0] avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Protection pins
  input  wire logic [NPROT-1:0]  prot_pin_in,
  output logic      [NPROT-1:0]  prot_pin_drive_out,
  output logic      [NPROT-1:0]  prot_pin_oe_out,
  // Sense and general pins, inputs only in this block
  input  wire logic [1:0]        sense_pin_in,
  input  wire logic [1:0]        general_pin_in,
  // External event pin
  input  wire logic              event_pin_in,
  output logic                   event_pin_drive_out,
  output logic                   event_pin_oe_out,
  // Interrupt
  output logic                   irq_out
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  bus_req_t          req;
  logic              wait_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rd_mux;
  logic              wr_acc;

  logic [NPROT-1:0]  prot_dir_reg;
  logic [NPROT-1:0]  prot_out_reg;
  logic              ext_dir_reg;
  logic              ext_out_reg;
  logic [NSRC-1:0]   irq_en_reg;
  logic [NSRC-1:0]   irq_pol_reg;
  logic [NSRC-1:0]   irq_pend_reg;
  logic [NSRC-1:0]   irq_pend_next;
  logic [NSRC-1:0]   irq_mask_reg;
  logic [NMODE-1:0]  pin_mode_reg;
  logic              irq_reg;

  logic [NSRC-1:0]   pins_raw;
  logic [NSRC-1:0]   sync1_reg;
  logic [NSRC-1:0]   sync2_reg;
  logic [NSRC-1:0]   prev_reg;
  logic [NSRC-1:0]   rise;
  logic [NSRC-1:0]   fall;
  logic [NSRC-1:0]   mode_ok;
  logic [NSRC-1:0]   set_vec;
  logic [NSRC-1:0]   clr_vec;

  assign req = '{rd:    avs_read_in,
                 wr:    avs_write_in,
                 addr:  avs_address_in,
                 wdata: avs_writedata_in,
                 be:    avs_byteenable_in};

  // All fields but mask bit 8 sit in byte lane 0; lane 0 alone gates every write
  assign wr_acc = req.wr && !wait_reg && req.be[0];

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait cycle per access: read data is registered before the
  // master samples waitrequest low, so it is stable at that edge.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wait_reg  <= 1'b1;
      rdata_reg <= '0;
    end else if ((req.rd || req.wr) && wait_reg) begin
      wait_reg <= 1'b0;
      if (req.rd) begin
        rdata_reg <= rd_mux;
      end
    end else begin
      wait_reg <= 1'b1;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (req.addr)
      PROT_DIR_ADDR:     rd_mux[NPROT-1:0] = prot_dir_reg;
      PROT_LEVEL_ADDR:   rd_mux[NPROT-1:0] = sync2_reg[NPROT-1:0];
      PROT_OUT_ADDR:     rd_mux[NPROT-1:0] = prot_out_reg;
      PIN_IRQ_EN_ADDR:   rd_mux[NPIN-1:0]  = irq_en_reg[NPIN-1:0];
      PIN_IRQ_POL_ADDR:  rd_mux[NPIN-1:0]  = irq_pol_reg[NPIN-1:0];
      PIN_IRQ_PEND_ADDR: rd_mux[NPIN-1:0]  = irq_pend_reg[NPIN-1:0];
      EXT_DIR_ADDR:      rd_mux[EXT_BIT]   = ext_dir_reg;
      EXT_LEVEL_ADDR:    rd_mux[EXT_BIT]   = sync2_reg[SRC_EXT];
      EXT_OUT_ADDR:      rd_mux[EXT_BIT]   = ext_out_reg;
      EXT_IRQ_EN_ADDR:   rd_mux[EXT_BIT]   = irq_en_reg[SRC_EXT];
      EXT_IRQ_POL_ADDR:  rd_mux[EXT_BIT]   = irq_pol_reg[SRC_EXT];
      EXT_IRQ_PEND_ADDR: rd_mux[EXT_BIT]   = irq_pend_reg[SRC_EXT];
      IRQ_MASK_ADDR:     rd_mux[NSRC-1:0]  = irq_mask_reg;
      PIN_MODE_ADDR:     rd_mux[NMODE-1:0] = pin_mode_reg;
      default:           rd_mux = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // Pin control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prot_dir_reg <= PROT_DIR_RST;
      prot_out_reg <= PROT_OUT_RST;
      ext_dir_reg  <= EXT_DIR_RST;
      ext_out_reg  <= EXT_OUT_RST;
    end else if (wr_acc) begin
      if (req.addr == PROT_DIR_ADDR) begin
        prot_dir_reg <= req.wdata[NPROT-1:0];
      end
      if (req.addr == PROT_OUT_ADDR) begin
        prot_out_reg <= req.wdata[NPROT-1:0];
      end
      if (req.addr == EXT_DIR_ADDR) begin
        ext_dir_reg <= req.wdata[EXT_BIT];
      end
      if (req.addr == EXT_OUT_ADDR) begin
        ext_out_reg <= req.wdata[EXT_BIT];
      end
    end
  end

  // Pad drivers; the value is only seen on the pin while enabled
  assign prot_pin_drive_out  = prot_out_reg;
  assign prot_pin_oe_out     = prot_dir_reg;
  assign event_pin_drive_out = ext_out_reg;
  assign event_pin_oe_out    = ext_dir_reg;

  // ---------------------------------------------------------------
  // Interrupt configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_en_reg   <= IRQ_EN_RST;
      irq_pol_reg  <= IRQ_POL_RST;
      irq_mask_reg <= IRQ_MASK_RST;
      pin_mode_reg <= PIN_MODE_RST;
    end else if (wr_acc) begin
      if (req.addr == PIN_IRQ_EN_ADDR) begin
        irq_en_reg[NPIN-1:0] <= req.wdata[NPIN-1:0];
      end
      if (req.addr == EXT_IRQ_EN_ADDR) begin
        irq_en_reg[SRC_EXT] <= req.wdata[EXT_BIT];
      end
      if (req.addr == PIN_IRQ_POL_ADDR) begin
        irq_pol_reg[NPIN-1:0] <= req.wdata[NPIN-1:0];
      end
      if (req.addr == EXT_IRQ_POL_ADDR) begin
        irq_pol_reg[SRC_EXT] <= req.wdata[EXT_BIT];
      end
      if (req.addr == IRQ_MASK_ADDR) begin
        irq_mask_reg <= req.wdata[NSRC-1:0];
      end
      if (req.addr == PIN_MODE_ADDR) begin
        pin_mode_reg <= req.wdata[NMODE-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers and edge detect
  // ---------------------------------------------------------------
  // Output pins are also sampled, so a driven pin can raise its own
  // event; software decides through the enable bits.
  assign pins_raw = {event_pin_in, general_pin_in, sense_pin_in,
                     prot_pin_in};

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise    = sync2_reg & ~prev_reg;
  assign fall    = ~sync2_reg & prev_reg;
  // Sense and general pins may only interrupt in general-purpose mode
  assign mode_ok = {1'b1, pin_mode_reg, {NPROT{1'b1}}};
  assign set_vec = irq_en_reg & mode_ok &
                   ((irq_pol_reg & rise) | (~irq_pol_reg & fall));

  // ---------------------------------------------------------------
  // Pending flags and interrupt line
  // ---------------------------------------------------------------
  always_comb begin
    clr_vec = '0;
    if (wr_acc && req.addr == PIN_IRQ_PEND_ADDR) begin
      clr_vec[NPIN-1:0] = req.wdata[NPIN-1:0];
    end
    if (wr_acc && req.addr == EXT_IRQ_PEND_ADDR) begin
      clr_vec[SRC_EXT] = req.wdata[EXT_BIT];
    end
  end

  // Set is ORed last so an event in the clearing cycle survives
  assign irq_pend_next = (irq_pend_reg & ~clr_vec) | set_vec;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_pend_reg <= IRQ_PEND_RST;
    end else begin
      irq_pend_reg <= irq_pend_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_pend_reg & irq_mask_reg);
    end
  end

  assign irq_out             = irq_reg;
  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_prot_drive;
    @(posedge clock_in) disable iff (sys_rst_in)
    (wr_acc && req.addr == PROT_OUT_ADDR)
      |=> prot_pin_drive_out == $past(req.wdata[NPROT-1:0]);
  endproperty
  a_prot_drive: assert property (p_prot_drive)
    else $error("protection drive value not updated");

  property p_prot_dir;
    @(posedge clock_in) disable iff (sys_rst_in)
    (wr_acc && req.addr == PROT_DIR_ADDR)
      |=> prot_pin_oe_out == $past(req.wdata[NPROT-1:0]);
  endproperty
  a_prot_dir: assert property (p_prot_dir)
    else $error("protection direction not updated");

  property p_prot_level;
    @(posedge clock_in) disable iff (sys_rst_in)
    !$past(sys_rst_in, 2)
      |-> sync2_reg[NPROT-1:0] == $past(prot_pin_in, 2);
  endproperty
  a_prot_level: assert property (p_prot_level)
    else $error("protection level not two cycles behind pin");

  property p_enable_gate;
    @(posedge clock_in) disable iff (sys_rst_in)
    ((irq_pend_reg & ~$past(irq_pend_reg) & ~$past(irq_en_reg)) == '0);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("pending bit set on disabled source");

  property p_mode_gate;
    @(posedge clock_in) disable iff (sys_rst_in)
    (!pin_mode_reg[0] && !irq_pend_reg[SRC_SENSE_LSB])
      |=> !irq_pend_reg[SRC_SENSE_LSB];
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("sense pin flag set outside general mode");

  property p_gen_mode_gate;
    @(posedge clock_in) disable iff (sys_rst_in)
    (!pin_mode_reg[2] && !irq_pend_reg[SRC_GEN_LSB])
      |=> !irq_pend_reg[SRC_GEN_LSB];
  endproperty
  a_gen_mode_gate: assert property (p_gen_mode_gate)
    else $error("general pin flag set outside general mode");

  property p_fall_sets;
    @(posedge clock_in) disable iff (sys_rst_in)
    (fall[0] && irq_en_reg[0] && !irq_pol_reg[0]) |=> irq_pend_reg[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling edge did not set pending");

  property p_ext_rise;
    @(posedge clock_in) disable iff (sys_rst_in)
    (rise[SRC_EXT] && irq_en_reg[SRC_EXT] && irq_pol_reg[SRC_EXT])
      |=> irq_pend_reg[SRC_EXT];
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("external rising edge did not set pending");

  property p_w1c;
    @(posedge clock_in) disable iff (sys_rst_in)
    (wr_acc && req.addr == PIN_IRQ_PEND_ADDR && req.wdata[1] && !set_vec[1])
      |=> !irq_pend_reg[1];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear pending");

  property p_w0_keeps;
    @(posedge clock_in) disable iff (sys_rst_in)
    (wr_acc && req.addr == PIN_IRQ_PEND_ADDR && !req.wdata[2]
     && irq_pend_reg[2]) |=> irq_pend_reg[2];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps)
    else $error("write of zero cleared pending");

  property p_set_wins;
    @(posedge clock_in) disable iff (sys_rst_in)
    (set_vec[SRC_EXT] && clr_vec[SRC_EXT]) |=> irq_pend_reg[SRC_EXT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear won over simultaneous event");

  property p_irq_level;
    @(posedge clock_in) disable iff (sys_rst_in)
    (|(irq_pend_reg & irq_mask_reg)) |=> irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt not raised for pending flag");

  property p_bus_answer;
    @(posedge clock_in) disable iff (sys_rst_in)
    (req.rd || req.wr) |-> ##[0:1] !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus access not answered in one cycle");

endmodule

// ---- include/gio_pkg.sv ----
// Constants and types shared by the fault and external pin GPIO block
package gio_pkg;

  // ---------------------------------------------------------------
  // Widths and source layout
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int BE_W    = 4;
  localparam int NPROT   = 4;
  localparam int NMODE   = 4;
  localparam int NPIN    = 8;
  localparam int NSRC    = 9;

  // Source index in the combined event vectors
  localparam int SRC_PROT_LSB  = 0;
  localparam int SRC_SENSE_LSB = 4;
  localparam int SRC_GEN_LSB   = 6;
  localparam int SRC_EXT       = 8;
  localparam int EXT_BIT       = 0;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PROT_DIR_ADDR     = 32'hfff7fa00;
  localparam logic [ADDR_W-1:0] PROT_LEVEL_ADDR   = 32'hfff7fa04;
  localparam logic [ADDR_W-1:0] PROT_OUT_ADDR     = 32'hfff7fa08;
  localparam logic [ADDR_W-1:0] PIN_IRQ_EN_ADDR   = 32'hfff7fa14;
  localparam logic [ADDR_W-1:0] PIN_IRQ_POL_ADDR  = 32'hfff7fa18;
  localparam logic [ADDR_W-1:0] PIN_IRQ_PEND_ADDR = 32'hfff7fa1c;
  localparam logic [ADDR_W-1:0] EXT_DIR_ADDR      = 32'hfff7fa20;
  localparam logic [ADDR_W-1:0] EXT_LEVEL_ADDR    = 32'hfff7fa24;
  localparam logic [ADDR_W-1:0] EXT_OUT_ADDR      = 32'hfff7fa28;
  localparam logic [ADDR_W-1:0] EXT_IRQ_EN_ADDR   = 32'hfff7fa34;
  localparam logic [ADDR_W-1:0] EXT_IRQ_POL_ADDR  = 32'hfff7fa38;
  localparam logic [ADDR_W-1:0] EXT_IRQ_PEND_ADDR = 32'hfff7fa3c;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR     = 32'hfff7fa40;
  localparam logic [ADDR_W-1:0] PIN_MODE_ADDR     = 32'hfff7fa44;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [NPROT-1:0] PROT_DIR_RST = 4'h0;
  localparam logic [NPROT-1:0] PROT_OUT_RST = 4'h0;
  localparam logic [NSRC-1:0]  IRQ_EN_RST   = 9'h000;
  localparam logic [NSRC-1:0]  IRQ_POL_RST  = 9'h000;
  localparam logic [NSRC-1:0]  IRQ_PEND_RST = 9'h000;
  localparam logic [NSRC-1:0]  IRQ_MASK_RST = 9'h1ff;
  localparam logic [NMODE-1:0] PIN_MODE_RST = 4'h0;
  localparam logic             EXT_DIR_RST  = 1'h0;
  localparam logic             EXT_OUT_RST  = 1'h0;

  // ---------------------------------------------------------------
  // Bus request carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [BE_W-1:0]   be;
  } bus_req_t;

endpackage

// ---- verification/pin_world_model.sv ----
// Model of the package pins seen from outside the gpio block
module pin_world_model
  import gio_pkg::*;
(
  // Design side of the pads
  input  wire logic [NPROT-1:0] prot_drive_in,
  input  wire logic [NPROT-1:0] prot_oe_in,
  input  wire logic             event_drive_in,
  input  wire logic             event_oe_in,
  // Levels the board puts on undriven pins
  input  wire logic [NPROT-1:0] prot_ext_in,
  input  wire logic             event_ext_in,
  // Resolved wire levels
  output logic      [NPROT-1:0] prot_level_out,
  output logic                  event_level_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // A pin the block drives shows the block's value, else the board's
  assign prot_level_out  = (prot_oe_in & prot_drive_in) |
                           (~prot_oe_in & prot_ext_in);
  assign event_level_out = event_oe_in ? event_drive_in : event_ext_in;
endmodule

// ---- verification/fault_and_ext_pin_gpio_irq_bench.sv ----
// Self-checking bench for the fault and external pin gpio block
module fault_and_ext_pin_gpio_irq_bench
  import gio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int LIMIT = 20000;
  logic              clock_in;
  logic              sys_rst_in;
  logic [ADDR_W-1:0] av_addr;
  logic              av_rd;
  logic              av_wr;
  logic [DATA_W-1:0] av_wd;
  logic [BE_W-1:0]   av_be;
  logic [DATA_W-1:0] avs_readdata_out;
  logic              avs_waitrequest_out;
  logic [NPROT-1:0]  prot_ext;
  logic [NPROT-1:0]  prot_lvl;
  logic [NPROT-1:0]  prot_pin_drive_out;
  logic [NPROT-1:0]  prot_pin_oe_out;
  logic [1:0]        sense;
  logic [1:0]        gen;
  logic              ev_ext;
  logic              ev_lvl;
  logic              event_pin_drive_out;
  logic              event_pin_oe_out;
  logic              irq_out;
  int                failures;
  int                checked;
  int                cycles;

  fault_ext_gpio fault_ext_gpio_i (
    .clock_in            (clock_in),
    .sys_rst_in          (sys_rst_in),
    .avs_address_in      (av_addr),
    .avs_read_in         (av_rd),
    .avs_write_in        (av_wr),
    .avs_writedata_in    (av_wd),
    .avs_byteenable_in   (av_be),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .prot_pin_in         (prot_lvl),
    .prot_pin_drive_out  (prot_pin_drive_out),
    .prot_pin_oe_out     (prot_pin_oe_out),
    .sense_pin_in        (sense),
    .general_pin_in      (gen),
    .event_pin_in        (ev_lvl),
    .event_pin_drive_out (event_pin_drive_out),
    .event_pin_oe_out    (event_pin_oe_out),
    .irq_out             (irq_out)
  );

  pin_world_model pin_world_model_i (
    .prot_drive_in   (prot_pin_drive_out),
    .prot_oe_in      (prot_pin_oe_out),
    .event_drive_in  (event_pin_drive_out),
    .event_oe_in     (event_pin_oe_out),
    .prot_ext_in     (prot_ext),
    .event_ext_in    (ev_ext),
    .prot_level_out  (prot_lvl),
    .event_level_out (ev_lvl)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low, released after that edge;
  // a slave that never answers is caught by the cycle limit
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_in);
    av_addr <= a;
    av_wd   <= d;
    av_wr   <= wr;
    av_rd   <= ~wr;
    do begin
      @(posedge clock_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic settle();
    repeat (8) @(posedge clock_in);
  endtask

  task automatic set_src(input int s, input logic v);
    @(posedge clock_in);
    if (s < 4) prot_ext[s] <= v;
    else if (s < 6) sense[s-4] <= v;
    else if (s < 8) gen[s-6] <= v;
    else ev_ext <= v;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic reset_values();
    logic [31:0] a [15];
    logic [31:0] e [15];
    a = '{PROT_DIR_ADDR, PROT_LEVEL_ADDR, PROT_OUT_ADDR, PIN_IRQ_EN_ADDR,
          PIN_IRQ_POL_ADDR, PIN_IRQ_PEND_ADDR, EXT_DIR_ADDR,
          EXT_LEVEL_ADDR, EXT_OUT_ADDR, EXT_IRQ_EN_ADDR, EXT_IRQ_POL_ADDR,
          EXT_IRQ_PEND_ADDR, IRQ_MASK_ADDR, PIN_MODE_ADDR, 32'hfff7fa0c};
    e = '{15{32'h0}};
    e[12] = 32'h1ff;
    for (int i = 0; i < 15; i++) rd_check(a[i], e[i]);
    check({27'h0, prot_pin_oe_out, event_pin_oe_out}, 32'h0);
    check({31'h0, irq_out}, 32'h0);
    wr(EXT_LEVEL_ADDR, 32'h1);
    rd_check(EXT_LEVEL_ADDR, 32'h0);
    // A write without lane 0 must leave every field alone
    av_be <= 4'he;
    wr(PROT_OUT_ADDR, 32'hf);
    av_be <= 4'hf;
    rd_check(PROT_OUT_ADDR, 32'h0);
  endtask

  task automatic drive_pins();
    prot_ext <= 4'h5;
    wr(PROT_OUT_ADDR, 32'hffff_fffa);
    settle();
    check({28'h0, prot_pin_oe_out}, 32'h0);
    rd_check(PROT_LEVEL_ADDR, 32'h5);
    rd_check(PROT_OUT_ADDR, 32'ha);
    wr(PROT_DIR_ADDR, 32'hf);
    settle();
    check({24'h0, prot_pin_oe_out, prot_pin_drive_out}, 32'hfa);
    rd_check(PROT_LEVEL_ADDR, 32'ha);
    wr(EXT_OUT_ADDR, 32'h1);
    check({31'h0, event_pin_oe_out}, 32'h0);
    wr(EXT_DIR_ADDR, 32'h1);
    settle();
    check({30'h0, event_pin_oe_out, event_pin_drive_out}, 32'h3);
    rd_check(EXT_LEVEL_ADDR, 32'h1);
    wr(PROT_DIR_ADDR, 32'h0);
    wr(EXT_DIR_ADDR, 32'h0);
    wr(EXT_OUT_ADDR, 32'h0);
    prot_ext <= 4'h0;
    settle();
    rd_check(EXT_LEVEL_ADDR, 32'h0);
  endtask

  // Sense and general pins ignore their enables outside general mode
  task automatic mode_gate();
    wr(PIN_MODE_ADDR, 32'h0);
    wr(PIN_IRQ_POL_ADDR, 32'hf0);
    wr(PIN_IRQ_EN_ADDR, 32'hf0);
    for (int s = 4; s < 8; s++) set_src(s, 1'b1);
    settle();
    rd_check(PIN_IRQ_PEND_ADDR, 32'h0);
    for (int s = 4; s < 8; s++) set_src(s, 1'b0);
    wr(PIN_IRQ_EN_ADDR, 32'h0);
    wr(PIN_MODE_ADDR, 32'hf);
  endtask

  // The edge reaches the flag in the very cycle the clear lands: set wins
  task automatic set_wins();
    wr(EXT_IRQ_POL_ADDR, 32'h1);
    wr(EXT_IRQ_EN_ADDR, 32'h1);
    fork
      set_src(8, 1'b1);
      begin
        @(posedge clock_in);
        wr(EXT_IRQ_PEND_ADDR, 32'h1);
      end
    join
    rd_check(EXT_IRQ_PEND_ADDR, 32'h1);
    wr(EXT_IRQ_EN_ADDR, 32'h0);
    set_src(8, 1'b0);
    wr(EXT_IRQ_PEND_ADDR, 32'h1);
    rd_check(EXT_IRQ_PEND_ADDR, 32'h0);
  endtask

  task automatic edge_case(input int s, input logic p);
    logic [31:0] pol_a;
    logic [31:0] en_a;
    logic [31:0] pnd_a;
    logic [31:0] b;
    pol_a = (s < 8) ? PIN_IRQ_POL_ADDR : EXT_IRQ_POL_ADDR;
    en_a  = (s < 8) ? PIN_IRQ_EN_ADDR : EXT_IRQ_EN_ADDR;
    pnd_a = (s < 8) ? PIN_IRQ_PEND_ADDR : EXT_IRQ_PEND_ADDR;
    b     = (s < 8) ? (32'h1 << s) : 32'h1;
    wr(pol_a, p ? b : 32'h0);
    wr(en_a, 32'h0);
    set_src(s, ~p);
    settle();
    wr(pnd_a, b);
    set_src(s, p);
    settle();
    rd_check(pnd_a, 32'h0);
    set_src(s, ~p);
    settle();
    wr(en_a, b);
    set_src(s, p);
    settle();
    rd_check(pnd_a, b);
    check({31'h0, irq_out}, 32'h1);
    wr(pnd_a, 32'h0);
    rd_check(pnd_a, b);
    wr(pnd_a, b);
    rd_check(pnd_a, 32'h0);
    settle();
    check({31'h0, irq_out}, 32'h0);
    set_src(s, ~p);
    settle();
    rd_check(pnd_a, 32'h0);
    wr(en_a, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    failures   = 0;
    checked    = 0;
    cycles     = 0;
    sys_rst_in = 1'b1;
    av_addr    = '0;
    av_rd      = 1'b0;
    av_wr      = 1'b0;
    av_wd      = '0;
    av_be      = 4'hf;
    prot_ext   = 4'h0;
    sense      = 2'h0;
    gen        = 2'h0;
    ev_ext     = 1'b0;
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    reset_values();
    drive_pins();
    mode_gate();
    for (int s = 0; s < NSRC; s++) begin
      edge_case(s, 1'b0);
      edge_case(s, 1'b1);
    end
    set_wins();
    results();
  end
endmodule
